// ==== pkg/asp_pkg.sv ====
// Shared constants, field layouts and state types for the asynchronous serial port
package asp_pkg;
  // ==========================================================================
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] ASP_OFF_CTRL = 8'h00;
  localparam logic [7:0] ASP_OFF_OPT = 8'h04;
  localparam logic [7:0] ASP_OFF_BAUD = 8'h08;
  localparam logic [7:0] ASP_OFF_STAT = 8'h0c;
  localparam logic [7:0] ASP_OFF_RXD = 8'h10;
  localparam logic [7:0] ASP_OFF_TXD = 8'h14;
  localparam logic [7:0] ASP_OFF_ISTAT = 8'h18;
  localparam logic [7:0] ASP_OFF_IMASK = 8'h1c;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic power;
    logic tx_en;
    logic rx_en;
    logic lsb_first;
    logic [1:0] parity;
    logic char8;
    logic stop2;
  } asp_ctrl_t;

  typedef struct packed {
    logic brk_req;
    logic [2:0] brk_sel;
    logic [1:0] pad;
    logic rx_inv;
    logic tx_inv;
  } asp_opt_t;

  localparam logic [7:0] ASP_CTRL_RST = 8'h10;
  localparam logic [7:0] ASP_OPT_RST = 8'h00;
  localparam logic [7:0] ASP_OPT_WMASK = 8'hf3;
  localparam logic [1:0] ASP_PAR_NONE = 2'h0;
  localparam logic [1:0] ASP_PAR_ZERO = 2'h1;
  localparam logic [1:0] ASP_PAR_ODD = 2'h2;
  localparam logic [1:0] ASP_PAR_EVEN = 2'h3;

  // Status bits: overrun, framing, parity, break, tx busy, rx data valid
  localparam int ASP_ST_OVR = 0;
  localparam int ASP_ST_FE = 1;
  localparam int ASP_ST_PE = 2;
  localparam int ASP_ST_SBF = 3;
  localparam int ASP_ST_TXB = 4;
  localparam int ASP_ST_RXV = 5;
  // Interrupt bits: rx done, tx free, rx error, break received
  localparam int ASP_IRQ_RX = 0;
  localparam int ASP_IRQ_TX = 1;
  localparam int ASP_IRQ_ERR = 2;
  localparam int ASP_IRQ_SBF = 3;

  // ==========================================================================
  // Timing
  localparam int ASP_CLK_HZ = 50000000;
  localparam int ASP_MIN_BPS = 300;
  localparam int ASP_OS = 16;
  localparam logic [3:0] ASP_OS_LAST = 4'(ASP_OS - 1);
  localparam logic [3:0] ASP_OS_HALF = 4'(ASP_OS / 2 - 1);
  localparam logic [15:0] ASP_BAUD_RST = 16'(ASP_CLK_HZ / (ASP_MIN_BPS * ASP_OS) - 1);
  localparam logic [4:0] ASP_BRK_TX_MIN = 5'h0d;
  localparam int ASP_BRK_RX_BITS = 11;
  localparam logic [7:0] ASP_BRK_RX_TICKS = 8'(ASP_BRK_RX_BITS * ASP_OS - 1);
  localparam logic [4:0] ASP_LEN7 = 5'h07;
  localparam logic [4:0] ASP_LEN8 = 5'h08;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} asp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_st_t;
endpackage

// ==== logic/asp_uart.sv ====
// Asynchronous serial port with break support, Wishbone register slave
// Functional notes
// - Receive-complete pulse each time a frame moves into the receive holding register.
// - Transmit-free pulse each time a byte moves from holding to shift register.
// - Character length seven or eight bits, for both directions.
// - Parity odd, even, forced zero, or none.
// - Transmit one or two stop bits as configured.
// - Output and input line levels may each be inverted.
// - Break transmit holds the line low for 13 to 20 bit times.
// - Receiver recognises a break after at least eleven low bit times.
// - A dedicated status flag records a received break.
// - Receiver reports parity, framing and overrun errors.
// - Own baud generator reaches down to 300 bit/s.
// - Error flags set on error, all cleared by a status read.
// - Power bit low holds the port in reset, output pin idle level.
// - Seven-bit LSB-first reception stores zero in the top bit.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module asp_uart
  import asp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic rx_done_irq,
  output logic tx_free_irq,
  output logic irq
);
  asp_ctrl_t ctrl_reg;
  asp_opt_t opt_reg;
  logic [15:0] baud_reg;
  logic [15:0] baud_cnt;
  logic os_tick;
  logic [3:0] imask_reg, istat_reg;
  logic [7:0] tx_holding_reg, tx_shift;
  logic tx_hold_full, tx_level, tx_load, tx_bit_end, brk_done;
  logic [3:0] tx_os;
  logic [4:0] tx_cnt;
  asp_tx_st_t tx_state;
  logic rx_sync1, rx_sync2, rx_prev, rx_line, rx_samp, rx_load, rx_pbit, rx_valid;
  logic [7:0] rx_holding_reg, rx_shift, rx_word;
  logic [3:0] rx_os;
  logic [4:0] rx_cnt;
  logic [7:0] low_cnt;
  logic sbf_set, pe_now;
  asp_rx_st_t rx_state;
  logic [3:0] rx_error_status;
  logic acc, wr, rd;
  logic [4:0] char_len;

  // ==========================================================================
  // Bus slave: one wait state, unmapped reads give zero
  assign acc = wb_cyc && wb_stb && !wb_ack;
  assign wr = acc && wb_we && wb_sel[0];
  assign rd = acc && !wb_we;
  assign char_len = ctrl_reg.char8 ? ASP_LEN8 : ASP_LEN7;

  always_ff @(posedge mclk)
  begin
    if (rst)
      wb_ack <= 1'b0;
    else
      wb_ack <= acc;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      wb_dat_r <= 32'h0;
    else if (rd)
    begin
      unique case (wb_adr)
        ASP_OFF_CTRL: wb_dat_r <= {24'h0, ctrl_reg};
        ASP_OFF_OPT: wb_dat_r <= {24'h0, opt_reg};
        ASP_OFF_BAUD: wb_dat_r <= {16'h0, baud_reg};
        ASP_OFF_STAT: wb_dat_r <= {26'h0, rx_valid, tx_hold_full || tx_state != TX_IDLE, rx_error_status};
        ASP_OFF_RXD: wb_dat_r <= {24'h0, rx_holding_reg};
        ASP_OFF_ISTAT: wb_dat_r <= {28'h0, istat_reg};
        ASP_OFF_IMASK: wb_dat_r <= {28'h0, imask_reg};
        default: wb_dat_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= asp_ctrl_t'(ASP_CTRL_RST);
    else if (wr && wb_adr == ASP_OFF_CTRL)
      ctrl_reg <= asp_ctrl_t'(wb_dat_w[7:0]);
  end

  // Break request bit self-clears once the break has gone out
  always_ff @(posedge mclk)
  begin
    if (rst)
      opt_reg <= asp_opt_t'(ASP_OPT_RST);
    else if (wr && wb_adr == ASP_OFF_OPT)
      opt_reg <= asp_opt_t'(wb_dat_w[7:0] & ASP_OPT_WMASK);
    else if (brk_done || !ctrl_reg.power)
      opt_reg.brk_req <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      baud_reg <= ASP_BAUD_RST;
    else if (acc && wb_we && wb_adr == ASP_OFF_BAUD)
    begin
      if (wb_sel[0])
        baud_reg[7:0] <= wb_dat_w[7:0];
      if (wb_sel[1])
        baud_reg[15:8] <= wb_dat_w[15:8];
    end
  end

  // ==========================================================================
  // Baud generator: oversampling tick, sixteen per bit
  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power)
      baud_cnt <= 16'h0;
    else if (os_tick)
      baud_cnt <= 16'h0;
    else
      baud_cnt <= baud_cnt + 16'h1;
  end
  assign os_tick = ctrl_reg.power && baud_cnt == baud_reg;

  // ==========================================================================
  // Transmitter
  function automatic logic [7:0] tx_order(input logic [7:0] d, input logic lsb, input logic c8);
    logic [7:0] r;
    r = 8'h0;
    for (int i = 0; i < 8; i++)
      r[i] = c8 ? d[7 - i] : (i < 7 ? d[6 - i] : 1'b0);
    return lsb ? (c8 ? d : {1'b0, d[6:0]}) : r;
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
    return mode == ASP_PAR_ODD ? ~^d : (mode == ASP_PAR_EVEN ? ^d : 1'b0);
  endfunction

  assign tx_load = tx_state == TX_IDLE && ctrl_reg.tx_en && !opt_reg.brk_req && tx_hold_full;
  assign tx_bit_end = os_tick && tx_os == ASP_OS_LAST;
  assign brk_done = tx_state == TX_BRK && tx_bit_end && tx_cnt == ASP_BRK_TX_MIN + 5'(opt_reg.brk_sel) - 5'h1;

  // New data written in the load cycle keeps the holding register full
  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power || !ctrl_reg.tx_en)
      tx_hold_full <= 1'b0;
    else if (wr && wb_adr == ASP_OFF_TXD)
      tx_hold_full <= 1'b1;
    else if (tx_load)
      tx_hold_full <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      tx_holding_reg <= 8'h0;
    else if (wr && wb_adr == ASP_OFF_TXD)
      tx_holding_reg <= wb_dat_w[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power || !ctrl_reg.tx_en)
    begin
      tx_state <= TX_IDLE;
      tx_level <= 1'b1;
      tx_os <= 4'h0;
      tx_cnt <= 5'h0;
      tx_shift <= 8'h0;
    end
    else
    begin
      if (tx_state == TX_IDLE)
        tx_os <= 4'h0;
      else if (os_tick)
        tx_os <= tx_os + 4'h1;
      unique case (tx_state)
        TX_IDLE:
          if (opt_reg.brk_req)
          begin
            tx_state <= TX_BRK;
            tx_level <= 1'b0;
            tx_cnt <= 5'h0;
          end
          else if (tx_load)
          begin
            tx_state <= TX_START;
            tx_level <= 1'b0;
            tx_shift <= tx_order(tx_holding_reg, ctrl_reg.lsb_first, ctrl_reg.char8);
          end
        TX_START:
          if (tx_bit_end)
          begin
            tx_state <= TX_DATA;
            tx_level <= tx_shift[0];
            tx_cnt <= 5'h0;
          end
        TX_DATA:
          if (tx_bit_end)
          begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_cnt <= tx_cnt + 5'h1;
            if (tx_cnt == char_len - 5'h1)
            begin
              if (ctrl_reg.parity == ASP_PAR_NONE)
              begin
                tx_state <= TX_STOP;
                tx_level <= 1'b1;
                tx_cnt <= 5'h0;
              end
              else
              begin
                tx_state <= TX_PAR;
                tx_level <= par_bit(ctrl_reg.char8 ? tx_holding_reg : {1'b0, tx_holding_reg[6:0]}, ctrl_reg.parity);
              end
            end
            else
              tx_level <= tx_shift[1];
          end
        TX_PAR:
          if (tx_bit_end)
          begin
            tx_state <= TX_STOP;
            tx_level <= 1'b1;
            tx_cnt <= 5'h0;
          end
        TX_STOP:
          if (tx_bit_end)
          begin
            if (ctrl_reg.stop2 && tx_cnt == 5'h0)
              tx_cnt <= 5'h1;
            else
              tx_state <= TX_IDLE;
          end
        TX_BRK:
          if (tx_bit_end)
          begin
            tx_cnt <= tx_cnt + 5'h1;
            if (brk_done)
            begin
              tx_state <= TX_STOP;
              tx_level <= 1'b1;
              tx_cnt <= 5'h0;
            end
          end
      endcase
    end
  end

  // Holding register stays in TX_DATA parity source, so software must not rewrite it mid-frame
  always_ff @(posedge mclk)
  begin
    if (rst)
      serial_out_pin <= 1'b1;
    else if (!ctrl_reg.power)
      serial_out_pin <= ~opt_reg.tx_inv;
    else
      serial_out_pin <= tx_level ^ opt_reg.tx_inv;
  end

  // ==========================================================================
  // Receiver
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_sync1 <= serial_in_pin;
      rx_sync2 <= rx_sync1;
      rx_prev <= rx_line;
    end
  end
  assign rx_line = rx_sync2 ^ opt_reg.rx_inv;
  assign rx_samp = os_tick && rx_os == ASP_OS_LAST;
  assign rx_load = rx_state == RX_STOP && rx_samp;
  assign rx_word = ctrl_reg.lsb_first ? (ctrl_reg.char8 ? rx_shift : {1'b0, rx_shift[7:1]})
                                      : (ctrl_reg.char8 ? rx_shift : {1'b0, rx_shift[6:0]});
  assign pe_now = ctrl_reg.parity[1] && rx_pbit != par_bit(rx_word, ctrl_reg.parity);

  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power || !ctrl_reg.rx_en)
    begin
      rx_state <= RX_IDLE;
      rx_os <= 4'h0;
      rx_cnt <= 5'h0;
      rx_shift <= 8'h0;
      rx_pbit <= 1'b0;
    end
    else
    begin
      if (os_tick)
        rx_os <= rx_os + 4'h1;
      unique case (rx_state)
        RX_IDLE:
          if (rx_prev && !rx_line)
          begin
            rx_state <= RX_START;
            rx_os <= 4'h0;
          end
        RX_START:
          if (os_tick && rx_os == ASP_OS_HALF)
          begin
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
            rx_os <= 4'h0;
            rx_cnt <= 5'h0;
            rx_shift <= 8'h0;
          end
        RX_DATA:
          if (rx_samp)
          begin
            rx_shift <= ctrl_reg.lsb_first ? {rx_line, rx_shift[7:1]} : {rx_shift[6:0], rx_line};
            rx_cnt <= rx_cnt + 5'h1;
            if (rx_cnt == char_len - 5'h1)
              rx_state <= ctrl_reg.parity == ASP_PAR_NONE ? RX_STOP : RX_PAR;
          end
        RX_PAR:
          if (rx_samp)
          begin
            rx_pbit <= rx_line;
            rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_samp)
            rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rx_holding_reg <= 8'h0;
    else if (rx_load)
      rx_holding_reg <= rx_word;
  end

  // Arrival wins over the read that empties the holding register
  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power)
      rx_valid <= 1'b0;
    else if (rx_load)
      rx_valid <= 1'b1;
    else if (rd && wb_adr == ASP_OFF_RXD)
      rx_valid <= 1'b0;
  end

  // Break detector: counts low time in oversample ticks, fires once per low stretch
  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power || !ctrl_reg.rx_en || rx_line)
      low_cnt <= 8'h0;
    else if (os_tick && low_cnt != ASP_BRK_RX_TICKS + 8'h1)
      low_cnt <= low_cnt + 8'h1;
  end
  assign sbf_set = os_tick && !rx_line && low_cnt == ASP_BRK_RX_TICKS;

  // Error flags: set wins over the clearing status read
  always_ff @(posedge mclk)
  begin
    if (rst || !ctrl_reg.power)
      rx_error_status <= 4'h0;
    else
    begin
      rx_error_status <= (rd && wb_adr == ASP_OFF_STAT) ? 4'h0 : rx_error_status;
      if (rx_load && rx_valid)
        rx_error_status[ASP_ST_OVR] <= 1'b1;
      if (rx_load && !rx_line)
        rx_error_status[ASP_ST_FE] <= 1'b1;
      if (rx_load && pe_now)
        rx_error_status[ASP_ST_PE] <= 1'b1;
      if (sbf_set)
        rx_error_status[ASP_ST_SBF] <= 1'b1;
    end
  end

  // ==========================================================================
  // Interrupts
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_done_irq <= 1'b0;
      tx_free_irq <= 1'b0;
    end
    else
    begin
      rx_done_irq <= rx_load;
      tx_free_irq <= tx_load;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      imask_reg <= 4'h0;
    else if (wr && wb_adr == ASP_OFF_IMASK)
      imask_reg <= wb_dat_w[3:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      istat_reg <= 4'h0;
    else
      istat_reg <= (istat_reg & ~((wr && wb_adr == ASP_OFF_ISTAT) ? wb_dat_w[3:0] : 4'h0))
                   | {sbf_set, rx_load && (rx_valid || !rx_line || pe_now), tx_load, rx_load};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(istat_reg & imask_reg);
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_start_bit;
    $rose(tx_state == TX_START);
  endsequence
  sequence s_low_bit;
    (tx_level == 1'b0) [*8];
  endsequence

  logic [4:0] brk_bits;
  always_ff @(posedge mclk)
  begin
    if (rst || tx_state != TX_BRK)
      brk_bits <= 5'h0;
    else if (tx_bit_end)
      brk_bits <= brk_bits + 5'h1;
  end

  a_rx_done_load:
    assert property (rx_load |=> rx_done_irq && rx_holding_reg == $past(rx_word))
    else $error("receive load without matching pulse or data");
  a_tx_free_move:
    assert property (tx_load |=> tx_free_irq && tx_state == TX_START)
    else $error("transmit load without free pulse");
  a_start_bit_low:
    assert property (s_start_bit |-> s_low_bit)
    else $error("start bit not low");
  a_break_length:
    assert property (brk_done |=> tx_state == TX_STOP && $past(brk_bits) == 5'd12 + 5'(opt_reg.brk_sel))
    else $error("break length wrong");
  a_break_detect:
    assert property (sbf_set |=> rx_error_status[ASP_ST_SBF] && low_cnt == ASP_BRK_RX_TICKS + 8'h1)
    else $error("break flag not set after eleven bits");
  a_overrun_flag:
    assert property (rx_load && rx_valid |=> rx_error_status[ASP_ST_OVR])
    else $error("overrun not flagged");
  a_read_clears:
    assert property (rd && wb_adr == ASP_OFF_STAT && !rx_load && !sbf_set |=> rx_error_status == 4'h0)
    else $error("status read did not clear flags");
  a_seven_top_zero:
    assert property (rx_done_irq && !ctrl_reg.char8 |-> rx_holding_reg[7] == 1'b0)
    else $error("seven-bit top bit not zero");
  a_power_idle_pin:
    assert property (!ctrl_reg.power [*2] |-> serial_out_pin == ~opt_reg.tx_inv || $changed(opt_reg))
    else $error("pin not idle while powered down");
endmodule

// ==== tb/asp_remote.sv ====
// Remote serial node model that drives and samples the two data lines
`timescale 1ns/100ps
module asp_remote #(
  parameter int BIT_CLKS = 32
)(
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  // ==========================================================================
  // Frame generation, LSB first, one bit every BIT_CLKS clocks
  initial line_out = 1'b1;

  task automatic hold(input logic lvl, input int bits);
    line_out <= lvl;
    repeat (bits * BIT_CLKS) @(posedge mclk);
  endtask

  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pb, input logic stp);
    @(posedge mclk);
    hold(1'b0, 1);
    for (int i = 0; i < n; i++)
      hold(d[i], 1);
    if (pen)
      hold(pb, 1);
    hold(stp, 1);
    line_out <= 1'b1;
  endtask

  // Long low level with no frame structure, used for break fields
  task automatic send_low(input int bits);
    @(posedge mclk);
    hold(1'b0, bits);
    line_out <= 1'b1;
  endtask

  // ==========================================================================
  // Capture, sampling at mid-bit; bounded so a silent line cannot hang
  task automatic wait_low();
    int k;
    k = 0;
    @(posedge mclk);
    while (line_in !== 1'b0 && k < 8000)
    begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic recv(input int n, input logic pen, output logic [7:0] d, output logic pb, output logic [1:0] st);
    d = 8'h00;
    pb = 1'b0;
    wait_low();
    repeat (BIT_CLKS / 2) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_CLKS) @(posedge mclk);
      d[i] = line_in;
    end
    if (pen)
    begin
      repeat (BIT_CLKS) @(posedge mclk);
      pb = line_in;
    end
    for (int i = 0; i < 2; i++)
    begin
      repeat (BIT_CLKS) @(posedge mclk);
      st[i] = line_in;
    end
  endtask

  task automatic low_len(output int c);
    wait_low();
    c = 1;
    while (line_in === 1'b0 && c < 2000)
    begin
      @(posedge mclk);
      c++;
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the asynchronous serial port
`timescale 1ns/100ps
module tb_top
  import asp_pkg::*;
;
  // ==========================================================================
  // Stimulus signals and instances
  localparam int BIT_CLKS = 32;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic serial_in_pin;
  logic serial_out_pin;
  logic rx_done_irq;
  logic tx_free_irq;
  logic irq;
  logic [31:0] v;
  logic [7:0] d;
  logic [1:0] st;
  logic [1:0] pm;
  logic got;
  logic pb;
  logic pe;
  int n;
  int c;
  int n_errors = 0;
  int check_count = 0;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data;
    logic bad_par;
    logic bad_stop;
    logic [7:0] exp_rx;
    logic [3:0] exp_err;
  } asp_row_t;

  // Every parity mode, both lengths, both stop counts, both bit orders, good and bad frames
  asp_row_t rows [7] = '{
    '{8'hf2, 8'ha5, 1'b0, 1'b0, 8'ha5, 4'h0},
    '{8'hff, 8'h3c, 1'b0, 1'b0, 8'h3c, 4'h0},
    '{8'hfa, 8'h81, 1'b1, 1'b0, 8'h81, 4'h4},
    '{8'hf4, 8'hff, 1'b1, 1'b0, 8'h7f, 4'h0},
    '{8'hf2, 8'h5a, 1'b0, 1'b1, 8'h5a, 4'h2},
    '{8'hf1, 8'h55, 1'b0, 1'b0, 8'h55, 4'h0},
    '{8'he2, 8'h01, 1'b0, 1'b0, 8'h80, 4'h0}
  };

  always #10 mclk = ~mclk;

  asp_uart i_dut (
    .mclk(mclk),
    .rst(rst),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_adr(wb_adr),
    .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack),
    .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin),
    .rx_done_irq(rx_done_irq),
    .tx_free_irq(tx_free_irq),
    .irq(irq)
  );

  asp_remote #(.BIT_CLKS(BIT_CLKS)) i_remote (
    .mclk(mclk),
    .line_in(serial_out_pin),
    .line_out(serial_in_pin)
  );

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t mismatch: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= wd;
    @(posedge mclk);
    while (wb_ack !== 1'b1 && k < 20)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 20)
      n_errors++;
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    wb_xfer(1'b1, a, wd, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic wait_pulse(input logic tx, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < 1500 && !seen; k++)
    begin
      @(posedge mclk);
      seen = tx ? (tx_free_irq === 1'b1) : (rx_done_irq === 1'b1);
    end
  endtask

  function automatic logic par_bit(input logic [1:0] m, input logic [7:0] dv, input int len);
    logic [7:0] t;
    t = (len == 7) ? {1'b0, dv[6:0]} : dv;
    return (m == ASP_PAR_ODD) ? ~^t : ((m == ASP_PAR_EVEN) ? ^t : 1'b0);
  endfunction

  // ==========================================================================
  // Main sequence; pins stay routed to the port throughout
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    check(serial_out_pin, 1'b1);
    rd(ASP_OFF_CTRL, v);
    check(v, 32'h10);
    rd(ASP_OFF_BAUD, v);
    check(v, 32'h28af);
    rd(8'h20, v);
    check(v, 32'h0);
    wr(ASP_OFF_OPT, 32'h1);
    repeat (2) @(posedge mclk);
    check(serial_out_pin, 1'b0);
    wr(ASP_OFF_OPT, 32'h0);
    wr(ASP_OFF_BAUD, 32'h1);
    foreach (rows[i])
    begin
      n = rows[i].ctrl[1] ? 8 : 7;
      pm = rows[i].ctrl[3:2];
      pe = (pm != ASP_PAR_NONE);
      wr(ASP_OFF_CTRL, {24'h0, rows[i].ctrl});
      fork
        i_remote.send(rows[i].data, n, pe, par_bit(pm, rows[i].data, n) ^ rows[i].bad_par, ~rows[i].bad_stop);
        wait_pulse(1'b0, got);
      join
      check(got, 1'b1);
      rd(ASP_OFF_STAT, v);
      check(v[3:0], rows[i].exp_err);
      rd(ASP_OFF_RXD, v);
      check(v, {24'h0, rows[i].exp_rx});
      // A second byte only without parity: a mid-frame write would disturb the parity bit
      fork
        i_remote.recv(n, pe, d, pb, st);
        begin
          wr(ASP_OFF_TXD, {24'h0, rows[i].data});
          wait_pulse(1'b1, got);
          if (!pe)
            wr(ASP_OFF_TXD, {24'h0, ~rows[i].data});
        end
      join
      check(got, 1'b1);
      check(d, rows[i].exp_rx);
      check(pb, pe ? par_bit(pm, rows[i].data, n) : 1'b0);
      check(st, {pe | rows[i].ctrl[0], 1'b1});
      repeat (14 * BIT_CLKS) @(posedge mclk);
    end
    wr(ASP_OFF_CTRL, 32'hf2);
    repeat (2) i_remote.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    repeat (40) @(posedge mclk);
    rd(ASP_OFF_STAT, v);
    check(v[0], 1'b1);
    rd(ASP_OFF_STAT, v);
    check(v[3:0], 4'h0);
    rd(ASP_OFF_RXD, v);
    for (int b = 10; b < 13; b += 2)
    begin
      i_remote.send_low(b);
      repeat (3 * BIT_CLKS) @(posedge mclk);
      rd(ASP_OFF_STAT, v);
      check(v[3], b > 11);
      rd(ASP_OFF_RXD, v);
    end
    // Inverted input turns the idle line into a standing break
    wr(ASP_OFF_OPT, 32'h2);
    repeat (12 * BIT_CLKS) @(posedge mclk);
    rd(ASP_OFF_STAT, v);
    check(v[3], 1'b1);
    wr(ASP_OFF_OPT, 32'h0);
    rd(ASP_OFF_RXD, v);
    for (int s = 0; s < 8; s += 7)
    begin
      fork
        i_remote.low_len(c);
        wr(ASP_OFF_OPT, {24'h0, 1'b1, 3'(s), 4'h0});
      join
      check(c >= (13 + s) * BIT_CLKS - 3 && c <= (13 + s) * BIT_CLKS + 3, 1'b1);
      repeat (3 * BIT_CLKS) @(posedge mclk);
      rd(ASP_OFF_OPT, v);
      check(v[7], 1'b0);
    end
    wr(ASP_OFF_IMASK, 32'h0);
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    wr(ASP_OFF_IMASK, 32'h1);
    repeat (2) @(posedge mclk);
    check(irq, 1'b1);
    wr(ASP_OFF_ISTAT, 32'hf);
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    rd(ASP_OFF_ISTAT, v);
    check(v, 32'h0);
    wr(ASP_OFF_OPT, 32'h1);
    repeat (2) @(posedge mclk);
    check(serial_out_pin, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    check(serial_out_pin, 1'b1);
    rst <= 1'b0;
    rd(ASP_OFF_CTRL, v);
    check(v, 32'h10);
    rd(ASP_OFF_OPT, v);
    check(v, 32'h0);
    finish_test();
  end

  // Watchdog sized well past the expected run of about 11000 clocks
  initial
  begin
    #1600000;
    n_errors++;
    finish_test();
  end
endmodule
